// File: hw/trp_host_port.sv
// Operation
// - Adjust mode: no start, relative stops
// - Lock visible; floating fallback, auto resume
// - Adjust works with high-res, not range2
// - Adjust mode needs no calibration run
// - Calibration measures one and two periods
// - Bit 7 starts calibration, self-clears
// - Auto calibration after hits on both, on stop 1 alone in high-res
// - Select raw hits, stepped ALU conversion
// - ALU: pass, calibrate, or multiply
// - Own ALU clock, about 2.56 us per division
// - Eight results, one or two registers
// - Write pointer wraps seven to zero
// - Result reads leave stored results unchanged
// - Seven control, four value, read registers
// - 8-bit data, 4-bit address, strobes
// - High latch enable makes latch transparent
// - Repeated reads auto increment counter
// - Status reads never increment
// - Noise offset on stops and calibration
// - Stop enable pins blank hits
// - Strobe spike filter; half resolution
// - Control 0 bit 3 auto calibration
// - Write registers cannot be read back
`timescale 1ns/1ns
`default_nettype none
`include "trp_cfg.svh"
module trp_host_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host port
    input wire logic [3:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic ale,
    input wire logic write_strobe_low,
    input wire logic read_strobe_low,
    input wire logic chip_select_low,
    // Measurement front end
    input wire logic start_pin,
    input wire logic stop1,
    input wire logic stop2,
    input wire logic stop1_en,
    input wire logic stop2_en,
    input wire logic cal_clk,
    input wire logic pll_lock,
    input wire logic [7:0] pll_proposal,
    // Mode outputs
    output logic [7:0] pll_factor,
    output logic [7:0] pll_adjust,
    output logic [5:0] hres_adjust,
    output logic high_res,
    output logic reso_active,
    output logic reso_floating,
    output logic alu_busy
);
    import trp_pkg::*;

    trp_state_s st;
    trp_state_s next_st;

    // Pick one raw hit by a channel/hit nibble; hit numbers run 1..4
    function automatic logic [15:0] sel_hit(input logic [1:0][3:0][15:0] h, input logic [3:0] nib);
        logic [2:0] idx;
        idx = nib[2:0] - 3'h1;
        sel_hit = h[nib[3]][idx[1:0]];
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [15:0] diff;
        logic [15:0] per;
        logic [23:0] fac;
        logic [2:0] lvl2;
        logic [2:0] rise;
        logic [3:0] eff;
        logic [3:0] ptr;
        logic [16:0] trial;
        logic [56:0] sum;
        logic [2:0] need;
        logic step_en;
        logic wr_take;
        logic rd_act;
        logic init;
        logic reso;
        next_st = st;
        // Selection follows the byte now being written, not the stale control 2
        diff = sel_hit(st.hit, st.din2[3:0]) - sel_hit(st.hit, st.din2[7:4]);
        per = st.cal2 - st.cal1;
        fac = {st.vr[2], st.vr[1], st.vr[0]};
        lvl2 = st.pin2[2:0] ^ st.cr[0][2:0];
        rise = lvl2 & ~(st.pin3[2:0] ^ st.cr[0][2:0]);
        eff = st.bus2[3] ? st.adr2 : st.alat;
        ptr = st.rd_ptr;
        trial = 17'h0;
        sum = 57'h0;
        need = st.cr[4][6:4];
        step_en = 1'b0;
        init = 1'b0;
        reso = st.reso_act;
        wr_take = 1'b0;
        rd_act = 1'b0;
        // Two-flop synchronisers on every pin except pll_proposal
        next_st.pin1 = {pll_lock, cal_clk, stop2_en, stop1_en, stop2, stop1, start_pin};
        next_st.pin2 = st.pin1;
        next_st.pin3 = st.pin2;
        next_st.bus1 = {ale, chip_select_low, read_strobe_low, write_strobe_low};
        next_st.bus2 = st.bus1;
        next_st.adr1 = addr;
        next_st.adr2 = st.adr1;
        next_st.din1 = data_in;
        next_st.din2 = st.din1;
        if (st.bus2[3]) begin
            next_st.alat = st.adr2;
        end
        // Spike filter on read and select; costs extra strobe latency
        for (int i = 0; i < 2; i++) begin
            if (!st.cr[4][`TRP_CR4_SPIKE]) begin
                next_st.filt[i] = st.bus2[i+1];
                next_st.fcnt[i] = 2'h0;
            end else if (st.bus2[i+1] == st.filt[i]) begin
                next_st.fcnt[i] = 2'h0;
            end else if (st.fcnt[i] == 2'(`TRP_FILT_CYC)) begin
                next_st.filt[i] = st.bus2[i+1];
                next_st.fcnt[i] = 2'h0;
            end else begin
                next_st.fcnt[i] = st.fcnt[i] + 2'h1;
            end
        end
        // Mode flags; adjust mode is locked out by the predivider range
        next_st.reso_act = st.cr[1][`TRP_CR1_RESO] & ~st.cr[0][`TRP_CR0_RANGE2];
        next_st.floating = st.reso_act & ~st.pin2[6];
        // Noise source and free counter for calibration
        next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[14] ^ st.lfsr[12] ^ st.lfsr[3]};
        next_st.free = st.free + 16'h1;
        // Time base; adjust mode ignores start and wraps freely
        if (rise[0] && !reso) begin
            init = 1'b1;
        end else if (reso || st.ts != 16'hffff) begin
            next_st.ts = st.ts + 16'h1;
        end
        // Stop capture, gated by enable pins; high-res turns stop 2 off
        for (int c = 0; c < 2; c++) begin
            if (rise[c+1] && st.pin2[3+c] && st.hcnt[c] < `TRP_MAX_HITS &&
                !(c == 1 && st.cr[1][`TRP_CR1_HRES])) begin
                next_st.hit[c][st.hcnt[c][1:0]] = st.ts + {12'h0, st.noise};
                next_st.hcnt[c] = st.hcnt[c] + 3'h1;
            end
        end
        // Calibration run, commanded or automatic
        if (!st.cal_busy && (st.cr[0][`TRP_CR0_CAL] ||
            (st.cr[0][`TRP_CR0_AUTO] && !reso && !st.cal_taken && need != 3'h0 && st.hcnt[0] >= need &&
             (st.hcnt[1] >= need || st.cr[1][`TRP_CR1_HRES])))) begin
            next_st.cal_busy = 1'b1;
            next_st.cal_edge = 2'h0;
            next_st.cal_taken = 1'b1;
        end
        if (st.cal_busy && st.pin2[5] && !st.pin3[5]) begin
            next_st.cal_edge = st.cal_edge + 2'h1;
            unique case (st.cal_edge)
                2'h0: next_st.cal_t0 = st.free;
                2'h1: next_st.cal1 = st.free - st.cal_t0 + {12'h0, st.noise};
                default: begin
                    next_st.cal2 = st.free - st.cal_t0 + {12'h0, st.noise};
                    next_st.cal_busy = 1'b0;
                    next_st.cal_valid = 1'b1;
                    next_st.cr[0][`TRP_CR0_CAL] = 1'b0;
                end
            endcase
        end
        // ALU stepping clock, adjustable by control 6
        if (st.alu != ALU_IDLE) begin
            if (st.tick == 4'h0) begin
                next_st.tick = st.cr[6][3:0];
                step_en = 1'b1;
            end else begin
                next_st.tick = st.tick - 4'h1;
            end
        end
        unique case (st.alu)
            ALU_IDLE: begin
            end
            ALU_DIV: begin
                if (step_en) begin
                    trial = {st.rem[15:0], st.quo[31]};
                    if (trial >= {1'b0, per}) begin
                        next_st.rem = trial - {1'b0, per};
                        next_st.quo = {st.quo[30:0], 1'b1};
                    end else begin
                        next_st.rem = trial;
                        next_st.quo = {st.quo[30:0], 1'b0};
                    end
                    next_st.step = st.step + 5'h1;
                    if (st.step == 5'(`TRP_DIV_STEPS - 1)) begin
                        next_st.step = 5'h0;
                        next_st.alu = st.do_mul ? ALU_MUL : ALU_WR;
                    end
                end
            end
            ALU_MUL: begin
                if (step_en) begin
                    sum = st.acc + (fac[st.step] ? {1'b0, st.quo, 24'h0} : 57'h0);
                    next_st.acc = sum >> 1;
                    next_st.step = st.step + 5'h1;
                    if (st.step == 5'(`TRP_MUL_STEPS - 1)) begin
                        next_st.quo = next_st.acc[54:23];
                        next_st.step = 5'h0;
                        next_st.alu = ALU_WR;
                    end
                end
            end
            ALU_WR: begin
                next_st.res[st.wp] = st.quo[15:0];
                if (st.two_reg) begin
                    next_st.res[st.wp + 3'h1] = st.quo[31:16];
                    next_st.wp = st.wp + 3'h2;
                end else begin
                    next_st.wp = st.wp + 3'h1;
                end
                next_st.alu = ALU_IDLE;
            end
            default: next_st.alu = ALU_IDLE;
        endcase
        // Host write on the rising write strobe while selected
        next_st.wr_prev = st.bus2[0];
        wr_take = st.bus2[0] && !st.wr_prev && !st.filt[1];
        if (wr_take) begin
            if (eff <= `TRP_A_CR_LAST) begin
                next_st.cr[eff[2:0]] = st.din2;
                if (eff == `TRP_A_INIT) begin
                    init = 1'b1;
                end
                if (eff == `TRP_A_SEL && st.alu == ALU_IDLE) begin
                    next_st.tick = st.cr[6][3:0];
                    next_st.step = 5'h0;
                    next_st.rem = 17'h0;
                    next_st.acc = 57'h0;
                    next_st.do_mul = st.cr[0][`TRP_CR0_MUL];
                    if (reso && (st.cr[0][`TRP_CR0_CALIB] || st.cr[0][`TRP_CR0_MUL])) begin
                        // Fixed resolution: value already scaled, skip division
                        next_st.quo = {diff, 16'h0};
                        next_st.two_reg = 1'b1;
                        next_st.alu = st.cr[0][`TRP_CR0_MUL] ? ALU_MUL : ALU_WR;
                    end else if (st.cr[0][`TRP_CR0_CALIB]) begin
                        next_st.quo = {diff, 16'h0};
                        next_st.two_reg = 1'b1;
                        next_st.alu = ALU_DIV;
                    end else begin
                        next_st.quo = {16'h0, st.cr[4][`TRP_CR4_HALF] ? {1'b0, diff[15:1]} : diff};
                        next_st.two_reg = 1'b0;
                        next_st.alu = ALU_WR;
                    end
                end
            end else if (eff <= `TRP_A_VR_LAST) begin
                next_st.vr[2'(eff - `TRP_A_VR0)] = st.din2;
            end
        end
        if (init) begin
            next_st.ts = 16'h0;
            next_st.hcnt = '0;
            next_st.cal_taken = 1'b0;
            next_st.noise = (st.cr[4][`TRP_CR4_NOISE] && !reso) ? st.lfsr[3:0] : 4'h0;
        end
        // Host read; only the pointer moves, stored data never changes
        rd_act = !st.filt[0] && !st.filt[1];
        next_st.rd_prev = rd_act;
        next_st.doe = rd_act;
        if (rd_act && !st.rd_prev) begin
            if (eff < `TRP_A_RES_END) begin
                if (!(st.last_res && eff == st.last_adr)) begin
                    ptr = {eff[2:0], 1'b0};
                end
                next_st.rd_ptr = ptr;
                next_st.dout = ptr[0] ? st.res[ptr[3:1]][15:8] : st.res[ptr[3:1]][7:0];
            end else if (eff == `TRP_A_ST0) begin
                next_st.dout = {st.busy, st.cal_busy, st.cal_valid | reso, st.pin2[6], st.floating, st.wp};
            end else if (eff == `TRP_A_ST1) begin
                next_st.dout = {reso, st.cr[1][`TRP_CR1_HRES], st.hcnt[1], st.hcnt[0]};
            end else if (eff == `TRP_A_PROP) begin
                next_st.dout = pll_proposal;
            end else begin
                next_st.dout = 8'h0;
            end
        end
        if (!rd_act && st.rd_prev) begin
            if (eff < `TRP_A_RES_END) begin
                next_st.rd_ptr = st.rd_ptr + 4'h1;
            end
            next_st.last_adr = eff;
            next_st.last_res = eff < `TRP_A_RES_END;
        end
        next_st.busy = next_st.alu != ALU_IDLE;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
            st.bus1 <= 4'h7;
            st.bus2 <= 4'h7;
            st.wr_prev <= 1'b1;
            st.filt <= 2'h3;
            st.cr[2] <= `TRP_CR2_RST;
            st.cr[3] <= `TRP_CR3_RST;
            st.cr[6] <= 8'(`TRP_ALU_DIV_RST);
            st.lfsr <= `TRP_LFSR_SEED;
            st.alu <= ALU_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign data_out = st.dout;
    assign data_oe = st.doe;
    assign pll_factor = st.cr[3];
    assign pll_adjust = st.vr[3];
    assign hres_adjust = st.cr[1][5:0];
    assign high_res = st.cr[1][`TRP_CR1_HRES];
    assign reso_active = st.reso_act;
    assign reso_floating = st.floating;
    assign alu_busy = st.busy;
endmodule // trp_host_port
`default_nettype wire

// File: hw/trp_cfg.svh
`ifndef TRP_CFG_SVH
`define TRP_CFG_SVH
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TRP_CLK_NS 20
`define TRP_SPIKE_NS 6
`define TRP_FILT_CYC ((`TRP_SPIKE_NS + `TRP_CLK_NS - 1) / `TRP_CLK_NS)
`define TRP_CALC_NS 2000
`define TRP_DIV_STEPS 32
`define TRP_MUL_STEPS 24
`define TRP_ALU_DIV_RST (`TRP_CALC_NS / `TRP_CLK_NS / `TRP_DIV_STEPS)
// ----------------------------------------------------------------------------
// Host addresses
// ----------------------------------------------------------------------------
`define TRP_A_CR_LAST 4'h6
`define TRP_A_SEL 4'h2
`define TRP_A_INIT 4'h5
`define TRP_A_VR0 4'h7
`define TRP_A_VR_LAST 4'ha
`define TRP_A_RES_END 4'h8
`define TRP_A_ST0 4'h8
`define TRP_A_ST1 4'h9
`define TRP_A_PROP 4'ha
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TRP_CR0_CAL 7
`define TRP_CR0_CALIB 6
`define TRP_CR0_MUL 5
`define TRP_CR0_RANGE2 4
`define TRP_CR0_AUTO 3
`define TRP_CR1_RESO 7
`define TRP_CR1_HRES 6
`define TRP_CR4_NOISE 0
`define TRP_CR4_SPIKE 1
`define TRP_CR4_HALF 2
`define TRP_CR2_RST 8'h55
`define TRP_CR3_RST 8'h80
`define TRP_LFSR_SEED 16'h0001
`define TRP_MAX_HITS 3'h4
`endif

// File: hw/trp_pkg.sv
package trp_pkg;
    typedef enum logic [3:0] {
        ALU_IDLE = 4'b0001,
        ALU_DIV = 4'b0010,
        ALU_MUL = 4'b0100,
        ALU_WR = 4'b1000
    } trp_alu_e;

    typedef struct packed {
        logic [6:0] pin1;
        logic [6:0] pin2;
        logic [6:0] pin3;
        logic [3:0] bus1;
        logic [3:0] bus2;
        logic [3:0] adr1;
        logic [3:0] adr2;
        logic [7:0] din1;
        logic [7:0] din2;
        logic wr_prev;
        logic [1:0] filt;
        logic [1:0][1:0] fcnt;
        logic rd_prev;
        logic [3:0] alat;
        logic [3:0] last_adr;
        logic last_res;
        logic [3:0] rd_ptr;
        logic [6:0][7:0] cr;
        logic [3:0][7:0] vr;
        logic [15:0] ts;
        logic [15:0] free;
        logic [15:0] lfsr;
        logic [3:0] noise;
        logic [1:0][3:0][15:0] hit;
        logic [1:0][2:0] hcnt;
        logic cal_busy;
        logic [1:0] cal_edge;
        logic [15:0] cal_t0;
        logic [15:0] cal1;
        logic [15:0] cal2;
        logic cal_valid;
        logic cal_taken;
        trp_alu_e alu;
        logic [31:0] quo;
        logic [16:0] rem;
        logic [56:0] acc;
        logic [4:0] step;
        logic [3:0] tick;
        logic do_mul;
        logic two_reg;
        logic [7:0][15:0] res;
        logic [2:0] wp;
        logic [7:0] dout;
        logic doe;
        logic reso_act;
        logic floating;
        logic busy;
    } trp_state_s;
endpackage

// File: verification/trp_host_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module trp_host_port_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host port and mode outputs
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic write_strobe_low,
    input wire logic read_strobe_low,
    input wire logic chip_select_low,
    input wire logic pll_lock,
    input wire logic [7:0] pll_factor,
    input wire logic [7:0] pll_adjust,
    input wire logic reso_active,
    input wire logic reso_floating,
    input wire logic alu_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------------------
    // Bus driving
    // ------------------------------------------------------------------------
    property p_oe_cause;
        $rose(data_oe) |-> !$past(read_strobe_low) && !$past(chip_select_low);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
    property p_oe_drop;
        read_strobe_low [*7] |-> !data_oe;
    endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus still driven");
    property p_dout_hold;
        read_strobe_low [*7] |-> $stable(data_out);
    endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("read data moved");
    // ------------------------------------------------------------------------
    // Registers and modes
    // ------------------------------------------------------------------------
    property p_regs_hold;
        write_strobe_low [*8] |-> $stable(pll_factor) && $stable(pll_adjust);
    endproperty
    a_regs_hold: assert property (p_regs_hold) else $error("register moved");
    property p_reset_vals;
        $rose(rst_n) |-> pll_factor == 8'h80 && pll_adjust == 8'h00 && !data_oe && !alu_busy;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
    property p_float_on;
        (reso_active && !pll_lock) [*5] |-> reso_floating;
    endproperty
    a_float_on: assert property (p_float_on) else $error("no fallback");
    property p_float_off;
        pll_lock [*5] |-> !reso_floating;
    endproperty
    a_float_off: assert property (p_float_off) else $error("no resume");
    property p_busy_bound;
        $rose(alu_busy) |-> ##[1:1000] !alu_busy;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("alu hung");
endmodule // trp_host_port_checker
bind trp_host_port trp_host_port_checker chk (.mclk(mclk), .rst_n(rst_n), .data_out(data_out),
    .data_oe(data_oe), .write_strobe_low(write_strobe_low), .read_strobe_low(read_strobe_low),
    .chip_select_low(chip_select_low), .pll_lock(pll_lock), .pll_factor(pll_factor),
    .pll_adjust(pll_adjust), .reso_active(reso_active), .reso_floating(reso_floating),
    .alu_busy(alu_busy));
`default_nettype wire

// File: verification/trp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module trp_host_model (
    // Clock
    input wire logic mclk,
    // Lines driven by the host
    output logic [3:0] addr,
    output logic [7:0] data_in,
    output logic ale,
    output logic write_strobe_low,
    output logic read_strobe_low,
    output logic chip_select_low,
    // Device side of the data bus
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    localparam int PH = 6;
    logic drv;
    logic [7:0] wdat;
    logic [7:0] last;
    // Undriven bus shows the inverse of its last level, so no read passes by luck
    assign data_in = drv ? wdat : (data_oe ? data_out : ~last);
    // Idle bus, latch held transparent
    initial begin
        addr = 4'h0;
        ale = 1'b1;
        write_strobe_low = 1'b1;
        read_strobe_low = 1'b1;
        chip_select_low = 1'b1;
        drv = 1'b0;
        wdat = 8'h00;
        last = 8'h00;
    end
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Six-cycle phases also cover the slower filtered strobes
    task automatic wr(logic [3:0] a, logic [7:0] d);
        addr = a;
        wdat = d;
        drv = 1'b1;
        chip_select_low = 1'b0;
        cyc(PH);
        write_strobe_low = 1'b0;
        cyc(PH);
        write_strobe_low = 1'b1;
        cyc(PH);
        chip_select_low = 1'b1;
        drv = 1'b0;
        last = d;
        cyc(PH);
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] q);
        addr = a;
        chip_select_low = 1'b0;
        read_strobe_low = 1'b0;
        cyc(PH);
        q = data_in;
        last = q;
        read_strobe_low = 1'b1;
        chip_select_low = 1'b1;
        cyc(PH);
    endtask
    // One-cycle read pulse, short enough for the filter to swallow
    task automatic glitch();
        chip_select_low = 1'b0;
        read_strobe_low = 1'b0;
        cyc(1);
        chip_select_low = 1'b1;
        read_strobe_low = 1'b1;
        cyc(PH);
    endtask
endmodule // trp_host_model
`default_nettype wire

// File: verification/trp_host_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module trp_host_port_test;
    import trp_pkg::*;
    logic mclk, rst_n, ale, ws_low, rs_low, cs_low, data_oe, oe_seen;
    logic start_pin, stop1, stop2, stop1_en, stop2_en, cal_clk, pll_lock;
    logic high_res, reso_active, reso_floating, alu_busy;
    logic [3:0] addr;
    logic [5:0] hres_adjust;
    logic [7:0] data_in, data_out, pll_proposal, pll_factor, pll_adjust, q;
    logic [7:0] exp_seq [7] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h80, 8'h07};
    int fails = 0;
    int comparisons = 0;
    trp_host_port dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .ale(ale), .write_strobe_low(ws_low), .read_strobe_low(rs_low),
        .chip_select_low(cs_low), .start_pin(start_pin), .stop1(stop1), .stop2(stop2), .stop1_en(stop1_en),
        .stop2_en(stop2_en), .cal_clk(cal_clk), .pll_lock(pll_lock), .pll_proposal(pll_proposal),
        .pll_factor(pll_factor), .pll_adjust(pll_adjust), .hres_adjust(hres_adjust), .high_res(high_res),
        .reso_active(reso_active), .reso_floating(reso_floating), .alu_busy(alu_busy));
    trp_host_model hm (.mclk(mclk), .addr(addr), .data_in(data_in), .ale(ale), .write_strobe_low(ws_low),
        .read_strobe_low(rs_low), .chip_select_low(cs_low), .data_out(data_out), .data_oe(data_oe));
    // ------------------------------------------------------------------------
    // Clocks
    // ------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Eight mclk per period, kept off the mclk edges so sampling is exact
    initial begin
        cal_clk = 1'b0;
        #3;
        forever #80 cal_clk = ~cal_clk;
    end
    always @(posedge mclk) if (data_oe) oe_seen <= 1'b1;
    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic chk(string what, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, s);
            fails++;
        end
    endtask
    task automatic rc(logic [3:0] a, logic [7:0] e);
        hm.rd(a, q);
        chk("read data", e, q);
    endtask
    // Launch the ALU; results are read only once it is idle again
    task automatic op(logic [7:0] sel);
        int n;
        hm.wr(4'h2, sel);
        n = 0;
        while (alu_busy !== 1'b0 && n < 1000) begin
            hm.cyc(1);
            n++;
        end
        chk("alu_busy", 8'h00, {7'h0, alu_busy});
    endtask
    task automatic pulse();
        stop1 = 1'b1;
        stop2 = 1'b1;
        hm.cyc(3);
        stop1 = 1'b0;
        stop2 = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Cut a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        report_and_stop();
    end
    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        start_pin = 1'b0;
        stop1 = 1'b0;
        stop2 = 1'b0;
        stop1_en = 1'b1;
        stop2_en = 1'b1;
        pll_lock = 1'b0;
        pll_proposal = 8'h00;
        oe_seen = 1'b0;
        hm.cyc(5);
        rst_n = 1'b1;
        hm.cyc(1);
        chk("pll_factor", 8'h80, pll_factor);
        // Two hits forty cycles apart, channel two blanked after its first hit, a third hit blanked
        hm.wr(4'h5, 8'h00);
        pulse();
        stop2_en = 1'b0;
        hm.cyc(37);
        pulse();
        stop1_en = 1'b0;
        hm.cyc(5);
        pulse();
        hm.cyc(5);
        stop1_en = 1'b1;
        rc(4'h9, 8'h0a);
        op(8'h12);
        hm.wr(4'h4, 8'h04);
        op(8'h12);
        rc(4'h0, 8'h28);
        rc(4'h0, 8'h00);
        rc(4'h0, 8'h14);
        rc(4'h8, 8'h02);
        rc(4'h1, 8'h14);
        rc(4'h1, 8'h00);
        // Seven more results wrap past the top register
        repeat (7) op(8'h12);
        rc(4'h8, 8'h01);
        rc(4'h0, 8'h14);
        hm.wr(4'h3, 8'h5a);
        chk("pll_factor", 8'h5a, pll_factor);
        hm.wr(4'ha, 8'h3c);
        chk("pll_adjust", 8'h3c, pll_adjust);
        hm.wr(4'h1, 8'hed);
        chk("hres_adjust", 8'h2d, {2'h0, hres_adjust});
        chk("high_res", 8'h01, {7'h0, high_res});
        chk("reso_active", 8'h01, {7'h0, reso_active});
        chk("reso_floating", 8'h01, {7'h0, reso_floating});
        // Adjust mode: a start pulse must not clear the hit counts
        start_pin = 1'b1;
        hm.cyc(3);
        start_pin = 1'b0;
        rc(4'h9, 8'hca);
        pll_lock = 1'b1;
        hm.cyc(6);
        chk("reso_floating", 8'h00, {7'h0, reso_floating});
        hm.wr(4'h0, 8'h10);
        chk("reso_active", 8'h00, {7'h0, reso_active});
        hm.wr(4'h1, 8'h00);
        rc(4'h3, 8'h14);
        pll_proposal = 8'hc3;
        rc(4'ha, 8'hc3);
        rc(4'hc, 8'h00);
        // Calibration run, then a calibrated and a multiplied result
        hm.wr(4'h0, 8'h80);
        hm.cyc(100);
        rc(4'h8, 8'h31);
        hm.wr(4'h0, 8'h40);
        op(8'h12);
        hm.wr(4'h9, 8'hc0);
        hm.wr(4'h0, 8'h60);
        op(8'h12);
        foreach (exp_seq[i]) rc(4'h1, exp_seq[i]);
        // Filter on: a one-cycle read pulse never reaches the bus
        hm.wr(4'h4, 8'h02);
        oe_seen = 1'b0;
        hm.glitch();
        chk("glitch", 8'h00, {7'h0, oe_seen});
        rc(4'h8, 8'h35);
        // Latch closed: the status address held from the last read still wins
        hm.ale = 1'b0;
        hm.cyc(3);
        rc(4'h0, 8'h35);
        hm.ale = 1'b1;
        // Automatic calibration once both channels hold one hit
        stop2_en = 1'b1;
        hm.wr(4'h4, 8'h12);
        hm.wr(4'h0, 8'h08);
        hm.wr(4'h5, 8'h00);
        pulse();
        rc(4'h8, 8'h75);
        report_and_stop();
    end
endmodule // trp_host_port_test
`default_nettype wire
